// file: lwd_core.sv
// Control core: control latch, window watchdog, bus path and wake logic.
`timescale 1ns/1ps
`include "lwd_regs.svh"
module lwd_core #(
   parameter int unsigned FRAME_GND_CYC = `LWD_FRAME_GND_US * `LWD_CLK_MHZ,
   parameter int unsigned FRAME_HIGH_CYC = `LWD_FRAME_HIGH_US * `LWD_CLK_MHZ,
   parameter int unsigned FRAME_OPEN_CYC = `LWD_FRAME_OPEN_US * `LWD_CLK_MHZ,
   parameter int unsigned WDR_LOW_CYC = `LWD_WDR_LOW_US * `LWD_CLK_MHZ,
   parameter int unsigned RST_ACT_CYC = `LWD_RST_ACT_US * `LWD_CLK_MHZ,
   parameter int unsigned DTO_CYC = `LWD_DTO_US * `LWD_CLK_MHZ,
   parameter int unsigned TOGGLE_CYC = `LWD_TOGGLE_US * `LWD_CLK_MHZ
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic serial_select_n,
   input wire logic kick_pin,
   input wire logic period_strap,
   input wire logic strap_open,
   input wire logic supply_undervoltage,
   input wire logic thermal_shutdown,
   input wire logic txd,
   input wire logic bus_dominant,
   input wire logic local_wake,
   input wire logic enable_pin,
   output logic bus_drive,
   output logic rxd,
   output logic host_reset_n,
   output logic supervisor_reset_n,
   output logic serial_control
);
   localparam int unsigned FILT_CYC = `LWD_FILT_US * `LWD_CLK_MHZ;
   localparam int unsigned WAKE_MIN_CYC = `LWD_WAKE_MIN_US * `LWD_CLK_MHZ;

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchronisers; only stage b is read by logic.
   logic [9:0] sync_a_ff, sync_b_ff, pins;
   assign pins = {enable_pin, local_wake, bus_dominant, txd, thermal_shutdown,
                  supply_undervoltage, strap_open, period_strap, kick_pin,
                  serial_select_n};
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sync_a_ff <= 10'h000;
         sync_b_ff <= 10'h000;
      end else begin
         sync_a_ff <= pins;
         sync_b_ff <= sync_a_ff;
      end
   end
   logic sel_s, kick_s, strap_s, open_s, uv_s, ts_s, txd_s, dom_s, lw_s, en_s;
   assign {en_s, lw_s, dom_s, txd_s, ts_s, uv_s, open_s, strap_s, kick_s,
           sel_s} = sync_b_ff;

   ////////////////////////////////////////////////////////////////////////
   // Control-method latch and registers.
   logic [1:0] boot_ff, nxt_boot;
   logic serial_ff, nxt_serial;
   logic [7:0] wake_a_ff, nxt_wake_a, wake_b_ff, nxt_wake_b;
   logic [7:0] mode_reg_ff, nxt_mode_reg, rd_data;
   logic err_ff, nxt_err;
   logic wr_stb, sdo;
   logic [6:0] addr;
   logic [7:0] wdata;
   lwd_pkg::lwd_mode_t mode_ff, nxt_mode;
   lwd_pkg::lwd_wd_t wd_ff, nxt_wd;

   // The synchronised select level is only valid two edges after release,
   // so the latch waits for it and then never looks at the pin again.
   always_comb begin
      nxt_boot = boot_ff;
      nxt_serial = serial_ff;
      if (boot_ff != 2'h3) begin
         nxt_boot = boot_ff + 2'h1;
         if (boot_ff == 2'h2) begin
            nxt_serial = sel_s;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         boot_ff <= 2'h0;
         serial_ff <= 1'b0;
      end else begin
         boot_ff <= nxt_boot;
         serial_ff <= nxt_serial;
      end
   end
   assign serial_control = serial_ff;

   lwd_serial u_serial (
      .clk(clk),
      .resetn(resetn),
      .sck_s(strap_s),
      .sel_n_s(sel_s | ~serial_ff),
      .sdi_s(kick_s),
      .rd_data(rd_data),
      .sdo(sdo),
      .wr_stb(wr_stb),
      .addr(addr),
      .wdata(wdata)
   );

   always_comb begin
      if (addr == `LWD_ADDR_WAKE_A) begin
         rd_data = wake_a_ff;
      end else if (addr == `LWD_ADDR_WAKE_B) begin
         rd_data = wake_b_ff;
      end else if (addr == `LWD_ADDR_MODE) begin
         rd_data = mode_reg_ff;
      end else if (addr == `LWD_ADDR_STATUS) begin
         rd_data = {err_ff, 1'b0, 3'(wd_ff), 3'(mode_ff)};
      end else begin
         rd_data = 8'h00;
      end
   end

   logic wd_kick, wd_fault_in;
   assign wd_fault_in = (wd_ff != lwd_pkg::wd_fault) &&
                        (nxt_wd == lwd_pkg::wd_fault);
   always_comb begin
      nxt_wake_a = wake_a_ff;
      nxt_wake_b = wake_b_ff;
      nxt_mode_reg = mode_reg_ff;
      nxt_err = err_ff;
      if (wr_stb) begin
         if (addr == `LWD_ADDR_WAKE_A) begin
            nxt_wake_a = wdata;
         end else if (addr == `LWD_ADDR_WAKE_B) begin
            nxt_wake_b = wdata;
         end else if (addr == `LWD_ADDR_MODE) begin
            nxt_mode_reg = wdata;
         end else if (addr == `LWD_ADDR_STATUS && wdata[`LWD_STATUS_ERR]) begin
            nxt_err = 1'b0;
         end
      end
      // The requested-mode field clears itself whenever the mode changes.
      if (mode_ff != nxt_mode) begin
         nxt_mode_reg[`LWD_MODE_REQ_HI:`LWD_MODE_REQ_LO] = 2'h0;
      end
      if (wd_fault_in) begin
         nxt_err = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         wake_a_ff <= `LWD_RST_WAKE_A;
         wake_b_ff <= `LWD_RST_WAKE_B;
         mode_reg_ff <= `LWD_RST_MODE;
         err_ff <= 1'b0;
      end else begin
         wake_a_ff <= nxt_wake_a;
         wake_b_ff <= nxt_wake_b;
         mode_reg_ff <= nxt_mode_reg;
         err_ff <= nxt_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Kick filter, local wake detection and mode sequencing.
   logic kf_ff, nxt_kf, lw_q_ff, nxt_lw_q, wreq_ff, nxt_wreq, tog_ff, nxt_tog;
   logic [31:0] kcnt_ff, nxt_kcnt, lcnt_ff, nxt_lcnt, mcnt_ff, nxt_mcnt;
   logic lw_wake, any_wake;
   logic [1:0] req;
   assign req = mode_reg_ff[`LWD_MODE_REQ_HI:`LWD_MODE_REQ_LO];

   always_comb begin
      nxt_kf = kf_ff;
      nxt_kcnt = 32'h0;
      if (kick_s != kf_ff) begin
         nxt_kcnt = kcnt_ff + 32'h1;
         if (kcnt_ff >= 32'(FILT_CYC - 1)) begin
            nxt_kf = kick_s;
            nxt_kcnt = 32'h0;
         end
      end
      // Until the control latch settles, the filter adopts the pin's level.
      // A kick pin parked high would otherwise read as a kick after reset.
      if (boot_ff != 2'h3) begin
         nxt_kf = kick_s;
         nxt_kcnt = 32'h0;
      end
      nxt_lw_q = lw_s;
      nxt_lcnt = lw_s ? lcnt_ff + 32'h1 : 32'h0;
      case (wake_a_ff[`LWD_WAKE_EDGE_HI:`LWD_WAKE_EDGE_LO])
         2'h0: lw_wake = lw_s != lw_q_ff;
         2'h1: lw_wake = lw_s & ~lw_q_ff;
         2'h2: lw_wake = ~lw_s & lw_q_ff;
         default: lw_wake = ~lw_s & lw_q_ff &&
                            lcnt_ff >= 32'(WAKE_MIN_CYC);
      endcase
      any_wake = lw_wake || dom_s || (!serial_ff && en_s);
      nxt_mode = mode_ff;
      nxt_mcnt = mcnt_ff + 32'h1;
      nxt_wreq = wreq_ff;
      nxt_tog = tog_ff;
      case (mode_ff)
         lwd_pkg::restart: begin
            nxt_wreq = 1'b0;
            if (uv_s) begin
               nxt_mcnt = 32'h0;
            end else if (mcnt_ff >= 32'(RST_ACT_CYC - 1)) begin
               nxt_mode = lwd_pkg::standby;
               nxt_wreq = 1'b1;
               nxt_tog = 1'b0;
               nxt_mcnt = 32'h0;
            end
         end
         lwd_pkg::standby: begin
            if (mode_reg_ff[`LWD_MODE_TOGGLE] &&
                mcnt_ff >= 32'(TOGGLE_CYC - 1)) begin
               nxt_tog = ~tog_ff;
               nxt_mcnt = 32'h0;
            end
            if (serial_ff ? req == 2'h1 : en_s) begin
               nxt_mode = lwd_pkg::normal;
            end else if (serial_ff && req == 2'h2) begin
               nxt_mode = lwd_pkg::fast;
            end else if (serial_ff && req == 2'h3) begin
               nxt_mode = lwd_pkg::sleep;
            end
         end
         lwd_pkg::normal, lwd_pkg::fast: begin
            nxt_wreq = 1'b0;
            if (serial_ff ? req == 2'h3 : !en_s) begin
               nxt_mode = lwd_pkg::sleep;
            end else if (serial_ff && req == 2'h1) begin
               nxt_mode = lwd_pkg::normal;
            end else if (serial_ff && req == 2'h2) begin
               nxt_mode = lwd_pkg::fast;
            end
         end
         default: begin
            nxt_mcnt = 32'h0;
            if (any_wake) begin
               nxt_mode = lwd_pkg::restart;
            end
         end
      endcase
      if (uv_s) begin
         nxt_mode = lwd_pkg::restart;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         kf_ff <= 1'b0;
         kcnt_ff <= 32'h0;
         lw_q_ff <= 1'b0;
         lcnt_ff <= 32'h0;
         mode_ff <= lwd_pkg::restart;
         mcnt_ff <= 32'h0;
         wreq_ff <= 1'b0;
         tog_ff <= 1'b0;
      end else begin
         kf_ff <= nxt_kf;
         kcnt_ff <= nxt_kcnt;
         lw_q_ff <= nxt_lw_q;
         lcnt_ff <= nxt_lcnt;
         mode_ff <= nxt_mode;
         mcnt_ff <= nxt_mcnt;
         wreq_ff <= nxt_wreq;
         tog_ff <= nxt_tog;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Window watchdog. Serial control uses the shortest frame.
   logic kf_q_ff, nxt_kf_q;
   logic [31:0] wcnt_ff, nxt_wcnt, frame, half;
   logic active, nxt_active;
   assign active = mode_ff inside {lwd_pkg::standby, lwd_pkg::normal,
                                   lwd_pkg::fast};
   assign nxt_active = nxt_mode inside {lwd_pkg::standby, lwd_pkg::normal,
                                        lwd_pkg::fast};
   always_comb begin
      nxt_kf_q = kf_ff;
      wd_kick = serial_ff ? (wr_stb && addr == `LWD_ADDR_KICK &&
                             wdata == `LWD_KICK_CODE)
                          : kf_ff != kf_q_ff;
      if (serial_ff || (!open_s && !strap_s)) begin
         frame = 32'(FRAME_GND_CYC);
      end else if (!open_s) begin
         frame = 32'(FRAME_HIGH_CYC);
      end else begin
         frame = 32'(FRAME_OPEN_CYC);
      end
      half = frame >> 1;
      nxt_wd = wd_ff;
      nxt_wcnt = wcnt_ff + 32'h1;
      case (wd_ff)
         lwd_pkg::wd_init: begin
            if (wd_kick) begin
               nxt_wd = lwd_pkg::wd_closed;
               nxt_wcnt = 32'h0;
            end else if (wcnt_ff >= frame - 32'h1) begin
               nxt_wd = lwd_pkg::wd_fault;
               nxt_wcnt = 32'h0;
            end
         end
         lwd_pkg::wd_closed: begin
            if (wd_kick) begin
               nxt_wd = lwd_pkg::wd_fault;
               nxt_wcnt = 32'h0;
            end else if (wcnt_ff >= half - 32'h1) begin
               nxt_wd = lwd_pkg::wd_open;
               nxt_wcnt = 32'h0;
            end
         end
         lwd_pkg::wd_open: begin
            if (wd_kick) begin
               nxt_wd = lwd_pkg::wd_closed;
               nxt_wcnt = 32'h0;
            end else if (wcnt_ff >= half - 32'h1) begin
               nxt_wd = lwd_pkg::wd_fault;
               nxt_wcnt = 32'h0;
            end
         end
         lwd_pkg::wd_fault: begin
            if (wcnt_ff >= 32'(WDR_LOW_CYC - 1)) begin
               nxt_wd = lwd_pkg::wd_init;
               nxt_wcnt = 32'h0;
            end
         end
         default: begin
            nxt_wcnt = 32'h0;
         end
      endcase
      if (!nxt_active) begin
         nxt_wd = lwd_pkg::wd_off;
         nxt_wcnt = 32'h0;
      end else if (nxt_mode != mode_ff) begin
         nxt_wd = lwd_pkg::wd_init;
         nxt_wcnt = 32'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         kf_q_ff <= 1'b0;
         wd_ff <= lwd_pkg::wd_off;
         wcnt_ff <= 32'h0;
      end else begin
         kf_q_ff <= nxt_kf_q;
         wd_ff <= nxt_wd;
         wcnt_ff <= nxt_wcnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus path and pin outputs.
   logic [31:0] dcnt_ff, nxt_dcnt;
   logic dto_ff, nxt_dto, drv_ff, nxt_drv, rxd_ff, nxt_rxd;
   logic hrst_ff, nxt_hrst, wdr_ff, nxt_wdr;
   logic xcvr_on, wd_evt;
   assign xcvr_on = mode_ff == lwd_pkg::normal || mode_ff == lwd_pkg::fast;
   assign wd_evt = serial_ff && mode_reg_ff[`LWD_MODE_WDEVT];
   always_comb begin
      nxt_dcnt = txd_s ? 32'h0 : dcnt_ff + 32'h1;
      nxt_dto = dto_ff;
      if (txd_s) begin
         nxt_dto = 1'b0;
      end else if (dcnt_ff >= 32'(DTO_CYC - 1)) begin
         nxt_dto = 1'b1;
         nxt_dcnt = dcnt_ff;
      end
      nxt_drv = xcvr_on && !txd_s && !nxt_dto && !ts_s;
      if (mode_ff == lwd_pkg::restart) begin
         nxt_rxd = 1'b1;
      end else if (xcvr_on) begin
         nxt_rxd = !dom_s;
      end else if (wreq_ff) begin
         nxt_rxd = mode_reg_ff[`LWD_MODE_TOGGLE] ? tog_ff : 1'b0;
      end else begin
         nxt_rxd = 1'b1;
      end
      if (wd_evt) begin
         nxt_hrst = nxt_wd != lwd_pkg::wd_fault;
      end else begin
         nxt_hrst = !uv_s && nxt_mode != lwd_pkg::restart;
      end
      nxt_wdr = nxt_wd != lwd_pkg::wd_fault;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dcnt_ff <= 32'h0;
         dto_ff <= 1'b0;
         drv_ff <= 1'b0;
         rxd_ff <= 1'b1;
         hrst_ff <= 1'b0;
         wdr_ff <= 1'b1;
      end else begin
         dcnt_ff <= nxt_dcnt;
         dto_ff <= nxt_dto;
         drv_ff <= nxt_drv;
         rxd_ff <= nxt_rxd;
         hrst_ff <= nxt_hrst;
         wdr_ff <= nxt_wdr;
      end
   end
   assign bus_drive = drv_ff;
   assign rxd = rxd_ff;
   assign host_reset_n = hrst_ff;
   assign supervisor_reset_n = serial_ff ? sdo : wdr_ff;

   ////////////////////////////////////////////////////////////////////////
   a_latch_hold: assert property (@(posedge clk) disable iff (!resetn)
      boot_ff == 2'h3 |=> $stable(serial_ff))
      else $error("control method changed after latch");
   a_early_kick: assert property (@(posedge clk) disable iff (!resetn)
      wd_ff == lwd_pkg::wd_closed && wd_kick && nxt_active &&
      nxt_mode == mode_ff |=> wd_ff == lwd_pkg::wd_fault)
      else $error("kick in closed window not flagged");
   a_open_kick: assert property (@(posedge clk) disable iff (!resetn)
      wd_ff == lwd_pkg::wd_open && wd_kick && nxt_mode == mode_ff
      |=> wd_ff == lwd_pkg::wd_closed && wcnt_ff == 32'h0)
      else $error("open window kick did not restart timer");
   a_wdr_low: assert property (@(posedge clk) disable iff (!resetn)
      !serial_ff && $rose(wd_ff == lwd_pkg::wd_fault) |=> !supervisor_reset_n)
      else $error("watchdog reset not driven low on error");
   a_wdr_bound: assert property (@(posedge clk) disable iff (!resetn)
      wd_ff == lwd_pkg::wd_fault |-> wcnt_ff < 32'(WDR_LOW_CYC))
      else $error("watchdog reset held too long");
   a_entry_init: assert property (@(posedge clk) disable iff (!resetn)
      mode_ff != nxt_mode && nxt_active |=> wd_ff == lwd_pkg::wd_init)
      else $error("no initial window on mode entry");
   a_thermal_off: assert property (@(posedge clk) disable iff (!resetn)
      ts_s |=> !bus_drive)
      else $error("transmitter active during thermal shutdown");
   a_dto_release: assert property (@(posedge clk) disable iff (!resetn)
      dcnt_ff >= 32'(DTO_CYC - 1) && !txd_s |=> !bus_drive)
      else $error("bus held past dominant timeout");
   a_restart_rxd: assert property (@(posedge clk) disable iff (!resetn)
      mode_ff == lwd_pkg::restart |=> rxd)
      else $error("receive output low in restart");
   a_wake_req: assert property (@(posedge clk) disable iff (!resetn)
      mode_ff == lwd_pkg::restart && nxt_mode == lwd_pkg::standby &&
      !mode_reg_ff[`LWD_MODE_TOGGLE] |=> ##1 !rxd)
      else $error("wake request not shown on receive output");
endmodule : lwd_core

// file: lwd_core_tb.sv
// Self-checking bench for the watchdog control core.
`timescale 1ns/1ps
`include "lwd_regs.svh"
module lwd_core_tb;
   logic clk, resetn, sck, sel_n, serial_in, uv, ts, txd, dom, en, sopen, lwake;
   logic bus_drive, rxd, host_reset_n, sup_n, ser;
   int mismatches = 0;
   int num_checks = 0;
   int n;
   logic [7:0] rd;
   lwd_core #(.FRAME_GND_CYC(8000), .WDR_LOW_CYC(50), .RST_ACT_CYC(20),
      .DTO_CYC(100)) dut (.clk(clk), .resetn(resetn),
      .serial_select_n(sel_n), .kick_pin(serial_in), .period_strap(sck),
      .strap_open(sopen), .supply_undervoltage(uv),
      .thermal_shutdown(ts),
      .txd(txd), .bus_dominant(dom), .local_wake(lwake), .enable_pin(en),
      .bus_drive(bus_drive), .rxd(rxd), .host_reset_n(host_reset_n),
      .supervisor_reset_n(sup_n), .serial_control(ser));
   lwd_host host (.clk(clk), .sdo(sup_n), .sck(sck), .sel_n(sel_n),
      .serial_in(serial_in));
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic power(input logic sel);
      @(negedge clk);
      resetn = 1'b0;
      host.pins(sel);
      repeat (3) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
   endtask : power
   task automatic wait_sup(input logic lvl, input int lim);
      n = 0;
      while (sup_n !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_sup
   task automatic rdr(input logic [6:0] a);
      host.xfer({1'b0, a, 8'h00}, rd);
   endtask : rdr
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer({1'b1, a, d}, rd);
   endtask : wr
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_sim();
   end
   initial begin
      resetn = 1'b0;
      uv = 1'b0;
      ts = 1'b0;
      txd = 1'b1;
      dom = 1'b0;
      en = 1'b0;
      sopen = 1'b0;
      lwake = 1'b0;
      power(1'b1);
      chk("serial_control", {7'h00, ser}, 8'h01);
      rdr(`LWD_ADDR_WAKE_A);
      chk("wake_a reset", rd, `LWD_RST_WAKE_A);
      rdr(`LWD_ADDR_WAKE_B);
      chk("wake_b reset", rd, `LWD_RST_WAKE_B);
      wr(`LWD_ADDR_WAKE_A, 8'h5a);
      rdr(`LWD_ADDR_WAKE_A);
      chk("wake_a rw", rd, 8'h5a);
      wr(`LWD_ADDR_KICK, 8'h00);
      rdr(`LWD_ADDR_STATUS);
      chk("wd init", {5'h00, rd[5:3]}, 8'h01);
      chk("standby", {5'h00, rd[2:0]}, 8'h01);
      wr(`LWD_ADDR_KICK, `LWD_KICK_CODE);
      rdr(`LWD_ADDR_STATUS);
      chk("wd kicked", {5'h00, rd[5:3]}, 8'h02);
      wr(`LWD_ADDR_MODE, 8'h06);
      wr(`LWD_ADDR_KICK, `LWD_KICK_CODE);
      wr(`LWD_ADDR_KICK, `LWD_KICK_CODE);
      chk("wd event", {7'h00, host_reset_n}, 8'h00);
      rdr(`LWD_ADDR_STATUS);
      chk("err sticky", {7'h00, rd[7]}, 8'h01);
      chk("fast mode", {5'h00, rd[2:0]}, 8'h03);
      $display("test serial control done");
      power(1'b0);
      chk("pin control", {7'h00, ser}, 8'h00);
      chk("rxd restart", {7'h00, rxd}, 8'h01);
      chk("reset restart", {7'h00, host_reset_n}, 8'h00);
      host.pins(1'b1);
      repeat (40) @(negedge clk);
      chk("latch kept", {7'h00, ser}, 8'h00);
      chk("wake request", {7'h00, rxd}, 8'h00);
      chk("reset good", {7'h00, host_reset_n}, 8'h01);
      en = 1'b1;
      repeat (10) @(negedge clk);
      txd = 1'b0;
      repeat (5) @(negedge clk);
      chk("tx dominant", {7'h00, bus_drive}, 8'h01);
      dom = 1'b1;
      ts = 1'b1;
      repeat (5) @(negedge clk);
      chk("rx dominant", {7'h00, rxd}, 8'h00);
      chk("thermal off", {7'h00, bus_drive}, 8'h00);
      ts = 1'b0;
      repeat (110) @(negedge clk);
      chk("dom timeout", {7'h00, bus_drive}, 8'h00);
      txd = 1'b1;
      dom = 1'b0;
      repeat (5) @(negedge clk);
      chk("rx recessive", {7'h00, rxd}, 8'h01);
      $display("test bus path done");
      wait_sup(1'b0, 9000);
      chk("missed kick", {7'h00, sup_n}, 8'h00);
      wait_sup(1'b1, 80);
      chk("reset width", {7'h00, n >= 48 && n <= 52}, 8'h01);
      host.kick();
      repeat (4500) @(negedge clk);
      host.kick();
      wait_sup(1'b0, 3000);
      chk("kick in open", {7'h00, sup_n}, 8'h01);
      host.kick();
      wait_sup(1'b0, 2300);
      chk("early kick", {7'h00, sup_n}, 8'h00);
      en = 1'b0;
      repeat (5) @(negedge clk);
      lwake = 1'b1;
      repeat (5) @(negedge clk);
      chk("local wake", {7'h00, host_reset_n}, 8'h00);
      repeat (30) @(negedge clk);
      chk("wake again", {7'h00, rxd}, 8'h00);
      uv = 1'b1;
      repeat (6) @(negedge clk);
      chk("undervoltage", {7'h00, host_reset_n}, 8'h00);
      $display("test pin watchdog done");
      end_sim();
   end
endmodule : lwd_core_tb

// file: lwd_host.sv
// Host processor model: serial master and watchdog kick driver.
`timescale 1ns/1ps
module lwd_host (
   input wire logic clk,
   input wire logic sdo,
   output logic sck,
   output logic sel_n,
   output logic serial_in
);
   initial begin
      sck = 1'b0;
      sel_n = 1'b1;
      serial_in = 1'b0;
   end
   task automatic pins(input logic s);
      sel_n = s;
      sck = 1'b0;
   endtask : pins
   // Eight clocks per serial half period leave room for the input syncs.
   task automatic xfer(input logic [15:0] w, output logic [7:0] r);
      @(negedge clk);
      sel_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         serial_in = w[i];
         repeat (8) @(negedge clk);
         if (i < 8) r[i] = sdo;
         sck = 1'b1;
         repeat (8) @(negedge clk);
         sck = 1'b0;
      end
      repeat (8) @(negedge clk);
      sel_n = 1'b1;
      serial_in = ~serial_in;
      repeat (8) @(negedge clk);
   endtask : xfer
   task automatic kick();
      @(negedge clk);
      serial_in = ~serial_in;
   endtask : kick
endmodule : lwd_host

// file: lwd_pkg.sv
// Types shared by the watchdog control core.
package lwd_pkg;
   typedef enum logic [2:0] {restart, standby, normal, fast, sleep} lwd_mode_t;
   typedef enum logic [2:0] {wd_off, wd_init, wd_closed, wd_open, wd_fault}
      lwd_wd_t;
endpackage : lwd_pkg

// file: lwd_regs.svh
// Register offsets, reset values, field positions and timing figures.
`ifndef LWD_REGS_SVH
`define LWD_REGS_SVH
`define LWD_ADDR_WAKE_A 7'h11
`define LWD_ADDR_WAKE_B 7'h12
`define LWD_ADDR_KICK 7'h15
`define LWD_ADDR_MODE 7'h16
`define LWD_ADDR_STATUS 7'h17
`define LWD_RST_WAKE_A 8'h04
`define LWD_RST_WAKE_B 8'h02
`define LWD_RST_MODE 8'h00
`define LWD_KICK_CODE 8'hff
`define LWD_MODE_REQ_HI 1
`define LWD_MODE_REQ_LO 0
`define LWD_MODE_WDEVT 2
`define LWD_MODE_TOGGLE 3
`define LWD_WAKE_EDGE_HI 7
`define LWD_WAKE_EDGE_LO 6
`define LWD_STATUS_ERR 7
`define LWD_CLK_MHZ 200
`define LWD_FRAME_GND_US 32000
`define LWD_FRAME_HIGH_US 480000
`define LWD_FRAME_OPEN_US 4800000
`define LWD_WDR_LOW_US 15000
`define LWD_RST_ACT_US 1000
`define LWD_DTO_US 20000
`define LWD_TOGGLE_US 100
`define LWD_FILT_US 10
`define LWD_WAKE_MIN_US 10
`endif

// file: lwd_serial.sv
// Serial slave: 16-bit frames, address byte (bit 7 set for write), data.
`timescale 1ns/1ps
module lwd_serial (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sck_s,
   input wire logic sel_n_s,
   input wire logic sdi_s,
   input wire logic [7:0] rd_data,
   output logic sdo,
   output logic wr_stb,
   output logic [6:0] addr,
   output logic [7:0] wdata
);
   logic sck_q_ff, nxt_sck_q;
   logic [4:0] cnt_ff, nxt_cnt;
   logic [15:0] sh_ff, nxt_sh;
   logic [7:0] out_ff, nxt_out;
   logic wr_ff, nxt_wr;
   logic [6:0] addr_ff, nxt_addr;
   logic [7:0] wdata_ff, nxt_wdata;
   logic rise, fall;

   assign rise = sck_s & ~sck_q_ff;
   assign fall = ~sck_s & sck_q_ff;

   always_comb begin
      nxt_sck_q = sck_s;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_out = out_ff;
      nxt_wr = 1'b0;
      nxt_addr = addr_ff;
      nxt_wdata = wdata_ff;
      if (sel_n_s) begin
         nxt_cnt = 5'h00;
         nxt_out = 8'h00;
      end else if (rise && cnt_ff != 5'h10) begin
         nxt_sh = {sh_ff[14:0], sdi_s};
         nxt_cnt = cnt_ff + 5'h01;
         if (cnt_ff == 5'h07) begin
            nxt_addr = sh_ff[5:0] == 6'h00 ? {sh_ff[5:0], sdi_s}
                                           : {sh_ff[5:0], sdi_s};
         end
         if (cnt_ff == 5'h0f) begin
            nxt_wdata = {sh_ff[6:0], sdi_s};
            nxt_wr = sh_ff[14];
         end
      end else if (fall && cnt_ff == 5'h08) begin
         nxt_out = rd_data;
      end else if (fall && cnt_ff > 5'h08) begin
         nxt_out = {out_ff[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         sck_q_ff <= 1'b0;
         cnt_ff <= 5'h00;
         sh_ff <= 16'h0000;
         out_ff <= 8'h00;
         wr_ff <= 1'b0;
         addr_ff <= 7'h00;
         wdata_ff <= 8'h00;
      end else begin
         sck_q_ff <= nxt_sck_q;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         out_ff <= nxt_out;
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
         wdata_ff <= nxt_wdata;
      end
   end

   assign sdo = out_ff[7];
   assign wr_stb = wr_ff;
   assign addr = addr_ff;
   assign wdata = wdata_ff;
endmodule : lwd_serial
